/* File: hw/seep_two_wire.sv */
// two-wire serial memory target: protocol engine, page buffer, array, program timer
`include "seep_map.svh"
module seep_two_wire #(
  parameter int unsigned PROG_CYCLES = `SEEP_PROG_CYCLES,
  parameter int unsigned FILT_CYCLES = `SEEP_FILT_CYCLES,
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h5, // arbitrary value
  parameter int unsigned MEM_BYTES = `SEEP_MEM_BYTES,
  parameter int unsigned PAGE_BYTES = `SEEP_PAGE_BYTES
) (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic WRITE_GUARD_I,
  input wire logic CHIP_SELECT_STRAP_HI_I,
  input wire logic CHIP_SELECT_STRAP_LO_I,
  output logic BUSY_O,
  output seep_pkg::seep_byte_t RD_BYTE_O
);
  import seep_pkg::*;

  localparam int unsigned PCW = $clog2(PROG_CYCLES + 1);
  localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);
  localparam logic [PCW-1:0] PAGE_SPAN = PCW'(PAGE_BYTES);

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic guard_f;
  logic sel_hi_f;
  logic sel_lo_f;

  // each pin: two flops, then the noise window
  seep_deglitch #(.STABLE_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b1)) u_scl (
    .clk_i(SYS_CLK_I), .srst_i(SRST_I), .ce_i(CE_I), .pin_i(SCL_I), .level_o(scl_f)
  );
  seep_deglitch #(.STABLE_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b1)) u_sda (
    .clk_i(SYS_CLK_I), .srst_i(SRST_I), .ce_i(CE_I), .pin_i(SDA_I), .level_o(sda_f)
  );
  seep_deglitch #(.STABLE_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b0)) u_guard (
    .clk_i(SYS_CLK_I), .srst_i(SRST_I), .ce_i(CE_I), .pin_i(WRITE_GUARD_I),
    .level_o(guard_f)
  );
  seep_deglitch #(.STABLE_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b0)) u_sel_hi (
    .clk_i(SYS_CLK_I), .srst_i(SRST_I), .ce_i(CE_I), .pin_i(CHIP_SELECT_STRAP_HI_I),
    .level_o(sel_hi_f)
  );
  seep_deglitch #(.STABLE_CYCLES(FILT_CYCLES), .RESET_LEVEL(1'b0)) u_sel_lo (
    .clk_i(SYS_CLK_I), .srst_i(SRST_I), .ce_i(CE_I), .pin_i(CHIP_SELECT_STRAP_LO_I),
    .level_o(sel_lo_f)
  );

  // ----------------------------------------------------------------
  // bus event decode
  // ----------------------------------------------------------------
  logic scl_q_r;
  logic sda_q_r;

  // previous filtered levels for edge detection
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (CE_I) begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  seep_state_e st_r;
  logic [3:0] bit_cnt_r;
  seep_byte_t shf_r;
  logic oe_r;
  logic rw_r;
  logic mack_r;
  logic busy_r;
  logic [PCW-1:0] prog_cnt_r;
  seep_addr_t addr_r;
  logic upper_address_bit_r;
  logic [PAGE_BYTES-1:0] page_vld_r;
  logic [4:0] page_base_r;
  seep_byte_t page_buf [PAGE_BYTES];
  seep_byte_t mem [MEM_BYTES];
  seep_byte_t rd_byte;

  logic act;
  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic ev_stop;
  logic byte_end;
  logic dev_match;
  logic dev_done;
  logic maddr_done;
  logic wbyte_take;
  logic ld_rd;
  logic prog_go;
  logic prog_end;

  // bus ignored entirely while programming
  assign act = CE_I & ~busy_r; // see RQ22
  assign ev_rise = act & scl_f & ~scl_q_r;
  assign ev_fall = act & ~scl_f & scl_q_r;
  assign ev_start = act & scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign ev_stop = act & scl_f & scl_q_r & ~sda_q_r & sda_f;
  assign byte_end = ev_fall & (bit_cnt_r == 4'd8);

  // type code, select straps; upper bit and direction taken later
  assign dev_match = (shf_r[`SEEP_AW_TYPE_MSB:`SEEP_AW_TYPE_LSB] == DEVICE_TYPE_CODE)
                   & (shf_r[`SEEP_AW_SEL_HI] == sel_hi_f)
                   & (shf_r[`SEEP_AW_SEL_LO] == sel_lo_f); // see RQ21
  assign dev_done = byte_end & (st_r == SEEP_DEVW);
  assign maddr_done = byte_end & (st_r == SEEP_MADDR);
  assign wbyte_take = byte_end & (st_r == SEEP_WDATA) & ~guard_f; // see RQ6
  assign ld_rd = ev_fall & (((st_r == SEEP_DEVACK) & rw_r) | ((st_r == SEEP_RACK) & mack_r));
  // stop after accepted data launches programming
  assign prog_go = ev_stop & (|page_vld_r); // see RQ5
  assign prog_end = CE_I & busy_r & (prog_cnt_r == PROG_LAST);
  assign rd_byte = mem[addr_r];

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // bit shifting, acknowledge drive and phase sequencing
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      st_r <= SEEP_IDLE;
      bit_cnt_r <= 4'h0;
      shf_r <= `SEEP_RST_BYTE;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (CE_I) begin
      if (busy_r) begin
        st_r <= SEEP_IDLE; // see RQ22
        oe_r <= 1'b0;
      end else if (ev_stop) begin
        st_r <= SEEP_IDLE; // see RQ13
        oe_r <= 1'b0;
      end else if (ev_start) begin
        st_r <= SEEP_DEVW;
        bit_cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end else begin
        case (st_r)
          SEEP_DEVW, SEEP_MADDR, SEEP_WDATA: begin
            if (ev_rise) begin
              shf_r <= {shf_r[6:0], sda_f};
              bit_cnt_r <= bit_cnt_r + 4'd1;
            end else if (byte_end) begin
              bit_cnt_r <= 4'h0;
              if (st_r == SEEP_DEVW) begin
                // either direction acks when idle, so a poll answers done
                if (dev_match) begin
                  oe_r <= 1'b1; // see RQ8, RQ9
                  rw_r <= shf_r[`SEEP_AW_RW];
                  st_r <= SEEP_DEVACK;
                end else begin
                  st_r <= SEEP_IDLE; // see RQ21
                end
              end else if (st_r == SEEP_MADDR) begin
                oe_r <= 1'b1; // see RQ6, RQ17
                st_r <= SEEP_MACK;
              end else if (guard_f) begin
                // guarded data byte: leave line high and drop out
                oe_r <= 1'b0; // see RQ6, RQ7
                st_r <= SEEP_IDLE;
              end else begin
                oe_r <= 1'b1; // see RQ2
                st_r <= SEEP_WACK;
              end
            end
          end
          SEEP_DEVACK: begin
            if (ev_fall) begin
              if (rw_r) begin
                oe_r <= ~rd_byte[7]; // see RQ12
                shf_r <= {rd_byte[6:0], 1'b0};
                bit_cnt_r <= 4'd1;
                st_r <= SEEP_RDATA;
              end else begin
                oe_r <= 1'b0;
                bit_cnt_r <= 4'h0;
                st_r <= SEEP_MADDR;
              end
            end
          end
          SEEP_MACK, SEEP_WACK: begin
            if (ev_fall) begin
              oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              st_r <= SEEP_WDATA; // see RQ2
            end
          end
          SEEP_RDATA: begin
            if (ev_fall) begin
              if (bit_cnt_r == 4'd8) begin
                oe_r <= 1'b0;
                st_r <= SEEP_RACK;
              end else begin
                oe_r <= ~shf_r[7]; // see RQ12
                shf_r <= {shf_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'd1;
              end
            end
          end
          SEEP_RACK: begin
            if (ev_rise) begin
              mack_r <= ~sda_f;
            end else if (ev_fall) begin
              if (mack_r) begin
                oe_r <= ~rd_byte[7]; // see RQ18
                shf_r <= {rd_byte[6:0], 1'b0};
                bit_cnt_r <= 4'd1;
                st_r <= SEEP_RDATA;
              end else begin
                // no ack: line stays released until next start or stop
                oe_r <= 1'b0; // see RQ24
                st_r <= SEEP_IDLE;
              end
            end
          end
          SEEP_IDLE: begin
            oe_r <= 1'b0;
          end
          default: begin
            st_r <= SEEP_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // address counter
  // ----------------------------------------------------------------
  // holds last accessed location plus one
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      addr_r <= `SEEP_RST_ADDR; // see RQ16
      upper_address_bit_r <= 1'b0;
    end else if (CE_I) begin
      if (dev_done & dev_match) begin
        upper_address_bit_r <= shf_r[`SEEP_AW_UPPER];
      end
      if (maddr_done) begin
        addr_r <= {upper_address_bit_r, shf_r}; // see RQ25, RQ17
      end else if (wbyte_take) begin
        // page offset only: stays inside the page
        addr_r[3:0] <= addr_r[3:0] + 4'd1; // see RQ3, RQ4, RQ15, RQ11
      end else if (ld_rd) begin
        // full-width increment wraps top of memory to zero
        addr_r <= addr_r + 9'd1; // see RQ11, RQ14, RQ18, RQ19
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------
  // collects up to a page of bytes; rewritten offsets overwrite
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      page_vld_r <= `SEEP_RST_MASK;
      page_base_r <= 5'h00;
    end else if (CE_I) begin
      if (ev_start | prog_end) begin
        page_vld_r <= `SEEP_RST_MASK;
      end else if (wbyte_take) begin
        page_buf[addr_r[3:0]] <= shf_r; // see RQ1, RQ4
        page_vld_r[addr_r[3:0]] <= 1'b1;
        page_base_r <= addr_r[8:4];
      end
    end
  end

  // ----------------------------------------------------------------
  // program cycle
  // ----------------------------------------------------------------
  // timed from the stop to the end of programming
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end else if (CE_I) begin
      if (prog_go) begin
        busy_r <= 1'b1;
        prog_cnt_r <= '0;
      end else if (busy_r) begin
        if (prog_end) begin
          busy_r <= 1'b0; // see RQ23
        end
        prog_cnt_r <= prog_cnt_r + 1'b1;
      end
    end
  end

  // array update: one buffered byte per cycle at the head of the cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (CE_I & busy_r & (prog_cnt_r < PAGE_SPAN)) begin
      if (page_vld_r[prog_cnt_r[3:0]]) begin
        mem[{page_base_r, prog_cnt_r[3:0]}] <= page_buf[prog_cnt_r[3:0]]; // see RQ1
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: data output held low, enable carries the bit
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      BUSY_O <= 1'b0;
      RD_BYTE_O <= `SEEP_RST_BYTE;
    end else if (CE_I) begin
      SDA_O <= 1'b0;
      SDA_OE_O <= oe_r;
      BUSY_O <= busy_r | prog_go;
      if (ld_rd) begin
        RD_BYTE_O <= rd_byte;
      end
    end
  end
endmodule // seep_two_wire

/* File: hw/seep_map.svh */
// constants for the two-wire serial memory target: timing, layout, address-word fields
//
// Functional notes
// RQ1: accept one to sixteen bytes, program together
// RQ2: further data bytes extend a write into page write
// RQ3: page write increments only the page offset
// RQ4: page offset wraps inside page, later bytes overwrite
// RQ5: stop after write data starts program cycle
// RQ6: guarded: ack address words, nack data, no programming
// RQ7: guarded page write nacked after first byte
// RQ8: write-direction address word doubles as busy poll
// RQ9: poll nacked while programming, acked when done
// RQ10: master starts reads with read/write bit one
// RQ11: address counter holds last accessed address plus one
// RQ12: current read acks then shifts byte msb first
// RQ13: master nack then stop ends a read
// RQ14: read past top of memory wraps to zero
// RQ15: write counter wraps within its page
// RQ16: counter undefined at power-up; master sets it first
// RQ17: dummy write then repeated start gives random read
// RQ18: master ack after read byte sends next byte
// RQ19: sequential read wraps to zero and continues
// RQ20: reject pulses under fifty ns on both lines
// RQ21: check type code and select straps; mismatch to standby
// RQ22: ignore bus while programming, then standby
// RQ23: program cycle lasts at most five milliseconds
// RQ24: no ack and no stop: release line, stop sending
// RQ25: array address from upper bit plus address byte
`ifndef SEEP_MAP_SVH
`define SEEP_MAP_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SEEP_CLK_PERIOD_NS 8
`define SEEP_FILT_NS 50
// least time: round up to whole cycles
`define SEEP_FILT_CYCLES ((`SEEP_FILT_NS + `SEEP_CLK_PERIOD_NS - 1) / `SEEP_CLK_PERIOD_NS)
`define SEEP_PROG_TIME_NS 5000000
// longest time: round down
`define SEEP_PROG_CYCLES (`SEEP_PROG_TIME_NS / `SEEP_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------
`define SEEP_MEM_BYTES 512
`define SEEP_PAGE_BYTES 16
`define SEEP_BYTE_BITS 8

// ----------------------------------------------------------------
// address word fields
// ----------------------------------------------------------------
`define SEEP_AW_TYPE_MSB 7
`define SEEP_AW_TYPE_LSB 4
`define SEEP_AW_SEL_HI 3
`define SEEP_AW_SEL_LO 2
`define SEEP_AW_UPPER 1
`define SEEP_AW_RW 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SEEP_RST_ADDR 9'h000
`define SEEP_RST_BYTE 8'h00
`define SEEP_RST_MASK 16'h0000

`endif

/* File: hw/seep_pkg.sv */
// types shared by the two-wire serial memory target
package seep_pkg;
  // bus-side protocol phases
  typedef enum logic [3:0] {
    SEEP_IDLE,
    SEEP_DEVW,
    SEEP_DEVACK,
    SEEP_MADDR,
    SEEP_MACK,
    SEEP_WDATA,
    SEEP_WACK,
    SEEP_RDATA,
    SEEP_RACK
  } seep_state_e;

  typedef logic [8:0] seep_addr_t;
  typedef logic [7:0] seep_byte_t;
endpackage

/* File: hw/seep_deglitch.sv */
// two-flop synchroniser followed by a stability filter for one pin
`include "seep_map.svh"
module seep_deglitch #(
  parameter int unsigned STABLE_CYCLES = `SEEP_FILT_CYCLES,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  logic meta_r;
  logic sync_r;
  logic [CW-1:0] cnt_r;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  // first flop is read only by the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= RESET_LEVEL;
      sync_r <= RESET_LEVEL;
    end else if (ce_i) begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  // new level taken only after it stands the full window
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
      level_o <= RESET_LEVEL;
    end else if (ce_i) begin
      if (sync_r == level_o) begin
        cnt_r <= '0;
      end else if (cnt_r == LAST) begin
        cnt_r <= '0;
        level_o <= sync_r; // see RQ20
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // seep_deglitch

/* File: verification/seep_two_wire_sva.sv */
// port-level assertion checker for the two-wire serial memory target
module seep_two_wire_sva #(
  parameter int unsigned PROG_CYCLES = 625000
) (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic WRITE_GUARD_I,
  input wire logic BUSY_O
);
  import seep_pkg::*;
  logic [31:0] busy_cnt_r;
  logic [7:0] since_stop_r;
  logic [7:0] since_fall_r;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  // length of the current program cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= BUSY_O ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // cycles since a raw stop and since a raw clock fall, saturating
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      since_stop_r <= 8'hFF;
      since_fall_r <= 8'hFF;
    end else begin
      since_stop_r <= (SCL_I && $past(SCL_I) && SDA_I && !$past(SDA_I)) ? 8'h00 :
        since_stop_r + {7'h00, since_stop_r != 8'hFF};
      since_fall_r <= (!SCL_I && $past(SCL_I)) ? 8'h00 :
        since_fall_r + {7'h00, since_fall_r != 8'hFF};
    end
  end
  a_busy_max: assert property (BUSY_O |-> busy_cnt_r < PROG_CYCLES + 3)
    else $error("program cycle too long");
  a_busy_min: assert property ($fell(BUSY_O) |-> busy_cnt_r + 2 >= PROG_CYCLES)
    else $error("program cycle cut short");
  a_busy_from_stop: assert property ($rose(BUSY_O) |-> since_stop_r < 8'd24)
    else $error("program cycle without a stop");
  a_quiet_busy: assert property (BUSY_O && $past(BUSY_O) |-> !SDA_OE_O)
    else $error("data line driven while programming");
  a_guard_no_prog: assert property ($rose(BUSY_O) |-> !WRITE_GUARD_I)
    else $error("programming while guarded");
  a_oe_stands: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
    else $error("data drive changed with clock high");
  a_oe_after_fall: assert property ($changed(SDA_OE_O) |-> since_fall_r < 8'd24)
    else $error("data drive changed away from a clock fall");
  a_pull_low_only: assert property (SDA_OE_O |-> !SDA_O)
    else $error("data line driven high");
  c_prog: cover property ($fell(BUSY_O));
  c_ack: cover property ($rose(SDA_OE_O) && !BUSY_O);
  c_guard_ack: cover property ($rose(SDA_OE_O) && WRITE_GUARD_I);
endmodule // seep_two_wire_sva

bind seep_two_wire seep_two_wire_sva #(.PROG_CYCLES(PROG_CYCLES)) seep_two_wire_sva_i (
  .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .WRITE_GUARD_I(WRITE_GUARD_I), .BUSY_O(BUSY_O));

/* File: verification/seep_bm.sv */
// behavioural two-wire bus controller running on the link clock
module seep_bm #(
  parameter int Q = 3
) (
  input wire logic lclk_i,
  input wire logic sda_i,
  input wire logic glitch_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines released, clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // third of a bit time
  task automatic wq();
    repeat (Q) @(posedge lclk_i);
  endtask
  // start or repeated start: data falls with clock high
  task automatic start();
    wq();
    sda_o <= 1'b1;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_o <= 1'b0;
    wq();
    scl_o <= 1'b0;
  endtask
  // stop: data rises with clock high
  task automatic stop();
    wq();
    sda_o <= 1'b0;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_o <= 1'b1;
  endtask
  // nine bits msb first, a one releases the line
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      wq();
      sda_o <= w[i];
      wq();
      scl_o <= 1'b1;
      if (glitch_i) begin
        #100 scl_o = 1'b0; // short dip to be filtered
        #40 scl_o = 1'b1;
      end
      wq();
      r[i] = sda_i;
      scl_o <= 1'b0;
    end
  endtask
endmodule // seep_bm

/* File: verification/seep_two_wire_tb_top.sv */
// self-checking bench for the two-wire serial memory target
module seep_two_wire_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import seep_pkg::*;
  localparam logic [3:0] TYPE = 4'h9; // arbitrary value
  // rows: guard, address, write byte, byte read back
  localparam logic [25:0] ROWS [4] = '{{1'b0, 9'h000, 8'hA5, 8'hA5},
    {1'b1, 9'h000, 8'h3C, 8'hA5}, {1'b0, 9'h1FF, 8'h5A, 8'h5A}, {1'b0, 9'h123, 8'hC3, 8'hC3}};
  logic sys_clk, lclk, srst, guard, strap_hi, strap_lo, glitch, scl, m_sda, sda_oe, busy;
  seep_byte_t rd_byte;
  wire logic sda = m_sda & ~sda_oe;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  seep_two_wire #(.PROG_CYCLES(1200), .DEVICE_TYPE_CODE(TYPE)) seep_two_wire_i (
    .SYS_CLK_I(sys_clk), .SRST_I(srst), .CE_I(1'b1), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_O(sda_oe), .WRITE_GUARD_I(guard), .CHIP_SELECT_STRAP_HI_I(strap_hi),
    .CHIP_SELECT_STRAP_LO_I(strap_lo), .BUSY_O(busy), .RD_BYTE_O(rd_byte));
  // two link cycles per third of a bit keeps the whole run well under the cycle budget
  seep_bm #(.Q(2)) seep_bm_i (.lclk_i(lclk), .sda_i(sda), .glitch_i(glitch), .scl_o(scl),
    .sda_o(m_sda));
  task automatic chk_byte(input seep_byte_t got, input seep_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  function automatic seep_byte_t aw(input logic up, input logic rw);
    return {TYPE, 2'b10, up, rw};
  endfunction
  task automatic send(input seep_byte_t b, input logic ack);
    logic [8:0] r;
    seep_bm_i.xfer({b, 1'b1}, r);
    chk_ack(r[0], ack);
  endtask
  task automatic recv(input logic ack, input seep_byte_t exp);
    logic [8:0] r;
    seep_bm_i.xfer({8'hFF, ack}, r);
    chk_byte(r[8:1], exp);
  endtask
  task automatic poll(input logic up, input logic was_busy);
    logic [8:0] r;
    int n;
    n = 0;
    r = 9'h001;
    while (r[0] !== 1'b0 && n < 12) begin
      seep_bm_i.start();
      seep_bm_i.xfer({aw(up, 1'b0), 1'b1}, r);
      n++;
    end
    chk_ack(r[0], 1'b0);
    chk_ack(n > 1, was_busy);
  endtask
  task automatic rd_at(input seep_addr_t a, input logic was_busy);
    poll(a[8], was_busy);
    send(a[7:0], 1'b0);
    seep_bm_i.start();
    send(aw(a[8], 1'b1), 1'b0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // system clock and an unrelated link clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    srst = 1'b1;
    guard = 1'b0;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    glitch = 1'b0;
    settle(4);
    srst <= 1'b0;
    settle(30);
    chk_byte(rd_byte, 8'h00);
    chk_ack(busy, 1'b0);
    for (int k = 0; k < 4; k++) begin
      guard <= ROWS[k][25];
      settle(20);
      seep_bm_i.start();
      send(aw(ROWS[k][24], 1'b0), 1'b0);
      send(ROWS[k][23:16], 1'b0);
      send(ROWS[k][15:8], ROWS[k][25]);
      if (ROWS[k][25]) send(8'h00, 1'b1);
      seep_bm_i.stop();
      rd_at(ROWS[k][24:16], !ROWS[k][25]);
      recv(1'b1, ROWS[k][7:0]);
      seep_bm_i.stop();
    end
    seep_bm_i.start();
    send(aw(1'b0, 1'b0), 1'b0);
    send(8'hF8, 1'b0);
    for (int i = 0; i < 24; i++) send(8'h40 + i[7:0], 1'b0);
    seep_bm_i.stop();
    poll(1'b0, 1'b1);
    seep_bm_i.stop();
    seep_bm_i.start();
    send(aw(1'b0, 1'b1), 1'b0);
    for (int o = 0; o < 16; o++) recv(o == 15, 8'h48 + o[7:0]);
    seep_bm_i.stop();
    rd_at(9'h1FF, 1'b0);
    recv(1'b1, 8'h5A);
    settle(60);
    chk_ack(sda_oe, 1'b0);
    seep_bm_i.stop();
    seep_bm_i.start();
    send(aw(1'b0, 1'b1), 1'b0);
    recv(1'b1, 8'hA5);
    seep_bm_i.stop();
    rd_at(9'h1FF, 1'b0);
    recv(1'b0, 8'h5A);
    recv(1'b1, 8'hA5);
    seep_bm_i.stop();
    strap_lo <= 1'b1;
    settle(20);
    seep_bm_i.start();
    send(aw(1'b0, 1'b0), 1'b1);
    seep_bm_i.stop();
    strap_lo <= 1'b0;
    glitch <= 1'b1;
    settle(20);
    rd_at(9'h123, 1'b0);
    glitch <= 1'b0;
    recv(1'b1, 8'hC3);
    seep_bm_i.stop();
    end_of_test();
  end
endmodule // seep_two_wire_tb_top
